// ### logic/smf_pkg.sv
// constants, types and register layout of the supply monitor flag logic
package smf_pkg;
	// special-function register address and power-on value
	localparam logic [7:0] SMF_CTRL_ADDR = 8'hDF;
	localparam logic [7:0] SMF_CTRL_RESET = 8'hDC;
	// bit positions in supply_monitor_control
	localparam int SMF_BIT_UNUSED = 7;
	localparam int SMF_BIT_CMP = 6;
	localparam int SMF_BIT_FLAG = 5;
	localparam int SMF_BIT_TRIP_HI = 4;
	localparam int SMF_BIT_TRIP_LO = 2;
	localparam int SMF_BIT_FAIL = 1;
	localparam int SMF_BIT_EN = 0;
	// reset values of the individual fields
	localparam logic SMF_UNUSED_VAL = 1'h1;
	localparam logic [2:0] SMF_TRIP_RESET = 3'h7;
	// trip select codes
	localparam logic [2:0] SMF_TRIP_463 = 3'h0;
	localparam logic [2:0] SMF_TRIP_437 = 3'h1;
	localparam logic [2:0] SMF_TRIP_308 = 3'h2;
	localparam logic [2:0] SMF_TRIP_293 = 3'h3;
	// trip levels in hundredths of a volt
	localparam logic [8:0] SMF_CV_463 = 9'h1CF;
	localparam logic [8:0] SMF_CV_437 = 9'h1B5;
	localparam logic [8:0] SMF_CV_308 = 9'h134;
	localparam logic [8:0] SMF_CV_293 = 9'h125;
	localparam logic [8:0] SMF_CV_263 = 9'h107;
	// clock and timing
	localparam int SMF_CLK_HZ = 200000000;
	localparam int SMF_CLK_PERIOD_NS = 5;
	localparam int SMF_SETTLE_MS = 256;
	localparam int SMF_SETTLE_CYCLES = SMF_SETTLE_MS * (SMF_CLK_HZ / 1000);
	localparam int SMF_GLITCH_NS = 1000;
	localparam int SMF_GLITCH_CYCLES =
		(SMF_GLITCH_NS + SMF_CLK_PERIOD_NS - 1) / SMF_CLK_PERIOD_NS;
	localparam int SMF_GLITCH_W = 8;
	localparam int SMF_SETTLE_W = 26;
	// register bus request from the core
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic [7:0] wdata;
	} smf_sfr_req_s;
	// settling sequence states
	typedef enum logic [1:0] {
		SMF_ST_GOOD,
		SMF_ST_LOW,
		SMF_ST_SETTLE
	} smf_state_e;
endpackage

// ### logic/smf_glitch_filter.sv
// two-flop synchroniser and stability filter for one comparator input
`timescale 1ns/1ps
module smf_glitch_filter #(
	parameter int STABLE_CYCLES = smf_pkg::SMF_GLITCH_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic level_in,
	output logic synced_out,
	output logic filtered_out
);
	// all state of the filter
	typedef struct packed {
		logic meta;
		logic sync;
		logic filt;
		logic [smf_pkg::SMF_GLITCH_W-1:0] cnt;
	} smf_filt_s;

	smf_filt_s st_r; // registered state
	smf_filt_s st_nxt; // next state

	// next state: accept a new level only after it held long enough
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.meta = level_in;
		st_nxt.sync = st_r.meta;
		if (st_r.sync == st_r.filt)
		begin
			// agreement, restart the stability count
			st_nxt.cnt = '0;
		end
		else if (st_r.cnt == smf_pkg::SMF_GLITCH_W'(STABLE_CYCLES - 1))
		begin
			// held for the whole window, take it
			st_nxt.filt = st_r.sync;
			st_nxt.cnt = '0;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	// state register, comparators read as good after reset
	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			st_r <= '{meta: 1'b1, sync: 1'b1, filt: 1'b1, cnt: '0};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign synced_out = st_r.sync;
	assign filtered_out = st_r.filt;
endmodule

// ### logic/smf_supply_monitor.sv
// supply monitor control register, low-supply flag and settling counter
`timescale 1ns/1ps
// Summary of operation
// - flag low analog or digital supply
// - register at DFH, resets DCH, byte only
// - interrupt only when enable bit set
// - read-only status tracks both comparators
// - filtered comparator low sets flag, requests interrupt
// - flag clears after 256 ms settling count
// - software may write flag directly
// - glitches cannot set flag or interrupt
// - bit layout unused to monitor enable
// - trip code decodes to supply level
module smf_supply_monitor #(
	parameter int SETTLE_CYCLES = smf_pkg::SMF_SETTLE_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire smf_pkg::smf_sfr_req_s sfr_req_in,
	input wire logic irq_enable_in,
	input wire logic analog_supply_ok_in,
	input wire logic digital_supply_ok_in,
	output logic [7:0] sfr_rdata_out,
	output logic irq_out,
	output logic [2:0] trip_select_out,
	output logic [8:0] trip_level_cv_out,
	output logic low_supply_flag_out
);
	// all state of the monitor
	typedef struct packed {
		smf_pkg::smf_state_e st;
		logic [smf_pkg::SMF_SETTLE_W-1:0] cnt;
		logic low_supply_flag;
		logic [2:0] trip_select;
		logic failing_supply_indicator;
		logic supply_monitor_enable;
		logic supply_compare_status;
		logic [7:0] rdata;
		logic irq;
		logic [8:0] trip_cv;
	} smf_mon_s;

	smf_mon_s st_r; // registered state
	smf_mon_s st_nxt; // next state
	logic analog_sync; // synchronised analog comparator
	logic digital_sync; // synchronised digital comparator
	logic analog_filt; // glitch-filtered analog comparator
	logic digital_filt; // glitch-filtered digital comparator
	logic ctrl_wr; // write hits the control register
	logic cmp_low; // filtered supplies low while enabled
	logic expire; // settling count reached its end
	logic [7:0] ctrl_val; // assembled register image

	// analog comparator conditioning
	smf_glitch_filter #(
		.STABLE_CYCLES(smf_pkg::SMF_GLITCH_CYCLES)
	) u_analog_filt (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.level_in(analog_supply_ok_in),
		.synced_out(analog_sync),
		.filtered_out(analog_filt)
	);

	// digital comparator conditioning
	smf_glitch_filter #(
		.STABLE_CYCLES(smf_pkg::SMF_GLITCH_CYCLES)
	) u_digital_filt (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.level_in(digital_supply_ok_in),
		.synced_out(digital_sync),
		.filtered_out(digital_filt)
	);

	// trip level lookup in hundredths of a volt
	function automatic logic [8:0] trip_cv(input logic [2:0] code);
		logic [8:0] cv;
		cv = smf_pkg::SMF_CV_263;
		case (code)
			smf_pkg::SMF_TRIP_463: cv = smf_pkg::SMF_CV_463;
			smf_pkg::SMF_TRIP_437: cv = smf_pkg::SMF_CV_437;
			smf_pkg::SMF_TRIP_308: cv = smf_pkg::SMF_CV_308;
			smf_pkg::SMF_TRIP_293: cv = smf_pkg::SMF_CV_293;
			default: cv = smf_pkg::SMF_CV_263;
		endcase
		return cv;
	endfunction

	// decode and helper terms
	always_comb
	begin
		// whole-byte address match, no single-bit access
		ctrl_wr = sfr_req_in.wr && (sfr_req_in.addr == smf_pkg::SMF_CTRL_ADDR);
		// either supply low, only while enabled
		cmp_low = st_r.supply_monitor_enable && !(analog_filt && digital_filt);
		expire = (st_r.cnt == smf_pkg::SMF_SETTLE_W'(SETTLE_CYCLES - 1));
		// register image, msb to lsb
		ctrl_val = '0;
		ctrl_val[smf_pkg::SMF_BIT_UNUSED] = smf_pkg::SMF_UNUSED_VAL;
		ctrl_val[smf_pkg::SMF_BIT_CMP] = st_r.supply_compare_status;
		ctrl_val[smf_pkg::SMF_BIT_FLAG] = st_r.low_supply_flag;
		ctrl_val[smf_pkg::SMF_BIT_TRIP_HI:smf_pkg::SMF_BIT_TRIP_LO] = st_r.trip_select;
		ctrl_val[smf_pkg::SMF_BIT_FAIL] = st_r.failing_supply_indicator;
		ctrl_val[smf_pkg::SMF_BIT_EN] = st_r.supply_monitor_enable;
	end

	// next state of the monitor
	always_comb
	begin
		st_nxt = st_r;
		// live comparator status, read only
		st_nxt.supply_compare_status = analog_sync && digital_sync;
		// software-owned control fields
		if (ctrl_wr)
		begin
			st_nxt.trip_select =
				sfr_req_in.wdata[smf_pkg::SMF_BIT_TRIP_HI:smf_pkg::SMF_BIT_TRIP_LO];
			st_nxt.supply_monitor_enable = sfr_req_in.wdata[smf_pkg::SMF_BIT_EN];
		end
		// settling sequence
		case (st_r.st)
			smf_pkg::SMF_ST_GOOD:
			begin
				st_nxt.cnt = '0;
				if (cmp_low)
				begin
					st_nxt.st = smf_pkg::SMF_ST_LOW;
				end
				else if (st_r.low_supply_flag && st_r.supply_monitor_enable)
				begin
					// flag written by software, time it out
					st_nxt.st = smf_pkg::SMF_ST_SETTLE;
				end
			end
			smf_pkg::SMF_ST_LOW:
			begin
				st_nxt.cnt = '0;
				if (!st_r.supply_monitor_enable)
				begin
					st_nxt.st = smf_pkg::SMF_ST_GOOD;
				end
				else if (!cmp_low)
				begin
					// supplies back, count from zero
					st_nxt.st = smf_pkg::SMF_ST_SETTLE;
				end
			end
			smf_pkg::SMF_ST_SETTLE:
			begin
				if (!st_r.supply_monitor_enable)
				begin
					st_nxt.st = smf_pkg::SMF_ST_GOOD;
					st_nxt.cnt = '0;
				end
				else if (cmp_low)
				begin
					// dropped again, restart later
					st_nxt.st = smf_pkg::SMF_ST_LOW;
					st_nxt.cnt = '0;
				end
				else if (expire)
				begin
					// settled, hardware clears the flag
					st_nxt.st = smf_pkg::SMF_ST_GOOD;
					st_nxt.cnt = '0;
					st_nxt.low_supply_flag = 1'b0;
				end
				else
				begin
					st_nxt.cnt = st_r.cnt + 1'b1;
				end
			end
			default:
			begin
				st_nxt.st = smf_pkg::SMF_ST_GOOD;
				st_nxt.cnt = '0;
			end
		endcase
		// software write of the flag overrides a settled clear
		if (ctrl_wr)
		begin
			st_nxt.low_supply_flag = sfr_req_in.wdata[smf_pkg::SMF_BIT_FLAG];
		end
		// a low supply while the monitor is enabled always wins over any clear
		if (cmp_low)
		begin
			st_nxt.low_supply_flag = 1'b1;
			st_nxt.failing_supply_indicator = !analog_filt;
		end
		// interrupt gated by the external enable bit
		st_nxt.irq = st_r.low_supply_flag && irq_enable_in;
		// trip level drive to the comparators
		st_nxt.trip_cv = trip_cv(st_r.trip_select);
		// read data for the control register, zero elsewhere
		st_nxt.rdata = (sfr_req_in.addr == smf_pkg::SMF_CTRL_ADDR) ? ctrl_val : '0;
	end

	// state register, power-on value of the control register
	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			st_r.st <= smf_pkg::SMF_ST_GOOD;
			st_r.cnt <= '0;
			st_r.low_supply_flag <= smf_pkg::SMF_CTRL_RESET[smf_pkg::SMF_BIT_FLAG];
			st_r.trip_select <= smf_pkg::SMF_TRIP_RESET;
			st_r.failing_supply_indicator <= smf_pkg::SMF_CTRL_RESET[smf_pkg::SMF_BIT_FAIL];
			st_r.supply_monitor_enable <= smf_pkg::SMF_CTRL_RESET[smf_pkg::SMF_BIT_EN];
			st_r.supply_compare_status <= smf_pkg::SMF_CTRL_RESET[smf_pkg::SMF_BIT_CMP];
			st_r.rdata <= '0;
			st_r.irq <= 1'b0;
			st_r.trip_cv <= smf_pkg::SMF_CV_263;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign sfr_rdata_out = st_r.rdata;
	assign irq_out = st_r.irq;
	assign trip_select_out = st_r.trip_select;
	assign trip_level_cv_out = st_r.trip_cv;
	assign low_supply_flag_out = st_r.low_supply_flag;
endmodule

// ### bench/smf_core.sv
// core model: register bus master and interrupt enable
`timescale 1ns/1ps
module smf_core (
	input wire logic sys_clk_in,
	input wire logic [7:0] rdata_in,
	output smf_pkg::smf_sfr_req_s req_out,
	output logic irq_enable_out
);
	// idle bus, interrupt enabled
	initial
	begin
		req_out = '0;
		irq_enable_out = 1'b1;
	end
	// byte write, held across one edge
	task automatic wr(input logic [7:0] d);
		@(posedge sys_clk_in);
		#1 req_out = {8'hDF, 1'b1, d};
		@(posedge sys_clk_in);
		#1 req_out.wr = 1'b0;
	endtask
	// byte read, data taken one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_in);
		#1 req_out.addr = a;
		@(posedge sys_clk_in);
		#1 d = rdata_in;
	endtask
	// interrupt enable bit of the second enable register
	task automatic ien(input logic v);
		@(posedge sys_clk_in);
		#1 irq_enable_out = v;
	endtask
endmodule

// ### bench/smf_supply_monitor_assertions.sv
// port assertions for the supply monitor
`timescale 1ns/1ps
module smf_supply_monitor_assertions #(
	parameter int SETTLE_CYCLES = 50
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire smf_pkg::smf_sfr_req_s sfr_req_in,
	input wire logic irq_enable_in,
	input wire logic analog_supply_ok_in,
	input wire logic digital_supply_ok_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic irq_out,
	input wire logic [2:0] trip_select_out,
	input wire logic [8:0] trip_level_cv_out,
	input wire logic low_supply_flag_out
);
	logic hit; // control register addressed
	logic ok; // both supplies good
	int good_run; // cycles in a row with both supplies good
	assign hit = sfr_req_in.addr == 8'hDF;
	assign ok = analog_supply_ok_in && digital_supply_ok_in;
	// run length of good supplies, cleared by any low
	always_ff @(posedge sys_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			good_run <= 0;
		end
		else if (ok)
		begin
			good_run <= good_run + 1;
		end
		else
		begin
			good_run <= 0;
		end
	end
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);
	a_irq_gated: assert property (
		irq_out == ($past(low_supply_flag_out) && $past(irq_enable_in)))
		else $error("irq mismatch");
	a_other_zero: assert property (!hit |=> sfr_rdata_out == 8'h00)
		else $error("bad read data");
	a_bit7_high: assert property (hit |=> sfr_rdata_out[7])
		else $error("bit 7 low");
	a_write_readback: assert property (
		sfr_req_in.wr && hit ##1 hit && !sfr_req_in.wr |=>
		(sfr_rdata_out & 8'h1D) == ($past(sfr_req_in.wdata, 2) & 8'h1D))
		else $error("readback mismatch");
	a_flag_set_cause: assert property (
		$rose(low_supply_flag_out) |-> $past(sfr_req_in.wr) || !$past(ok, 10))
		else $error("flag set unprompted");
	a_flag_clear_ok: assert property (
		$fell(low_supply_flag_out) |-> $past(ok, 10))
		else $error("flag cleared early");
	a_code0_level: assert property (
		(trip_select_out == 3'h0) [*3] |-> trip_level_cv_out == 9'h1CF)
		else $error("level for 000 wrong");
	a_code4_level: assert property (
		trip_select_out[2] [*3] |-> trip_level_cv_out == 9'h107)
		else $error("level for 1xx wrong");
	a_clear_after_settle: assert property (
		$fell(low_supply_flag_out) && !$past(sfr_req_in.wr) |-> good_run > SETTLE_CYCLES)
		else $error("flag cleared before settling");
endmodule
bind smf_supply_monitor smf_supply_monitor_assertions
	#(.SETTLE_CYCLES(SETTLE_CYCLES)) asrt_i (
	.sys_clk_in(sys_clk_in), .reset_in(reset_in), .sfr_req_in(sfr_req_in),
	.irq_enable_in(irq_enable_in), .analog_supply_ok_in(analog_supply_ok_in),
	.digital_supply_ok_in(digital_supply_ok_in), .sfr_rdata_out(sfr_rdata_out),
	.irq_out(irq_out), .trip_select_out(trip_select_out),
	.trip_level_cv_out(trip_level_cv_out), .low_supply_flag_out(low_supply_flag_out));

// ### bench/tb_top.sv
// self-checking bench for the supply monitor flag logic
`timescale 1ns/1ps
module tb_top;
	localparam int SETTLE = 400; // shortened settling count, longer than the glitch window
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ana = 1'b1; // analog comparator, high is good
	logic dig = 1'b1; // digital comparator
	smf_pkg::smf_sfr_req_s req;
	logic ien;
	logic [7:0] rd;
	logic irq;
	logic [2:0] trip;
	logic [8:0] cv;
	logic flag;
	logic [8:0] lv [5] = '{9'h1CF, 9'h1B5, 9'h134, 9'h125, 9'h107}; // levels per code
	int n_fail = 0;
	int n_tests = 0;
	// 200 MHz clock
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	smf_core smf_core_i (.sys_clk_in(clk), .rdata_in(rd), .req_out(req),
		.irq_enable_out(ien));
	smf_supply_monitor #(.SETTLE_CYCLES(SETTLE)) smf_supply_monitor_i (.sys_clk_in(clk),
		.reset_in(rst), .sfr_req_in(req), .irq_enable_in(ien), .analog_supply_ok_in(ana),
		.digital_supply_ok_in(dig), .sfr_rdata_out(rd), .irq_out(irq),
		.trip_select_out(trip), .trip_level_cv_out(cv), .low_supply_flag_out(flag));
	// compare one value
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		smf_core_i.rd(a, d);
		chk(d, e);
	endtask
	// bounded wait for the flag level, looked at once each edge has settled
	task automatic wait_flag(input logic v, input int lim);
		int i;
		i = 0;
		while (i < lim && flag !== v)
		begin
			@(posedge clk);
			#1;
			i++;
		end
		chk(flag, v);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		chk(trip, 3'h7);
		chk(cv, 9'h107);
		rchk(8'hDF, 8'hDC);
		rchk(8'h3A, 8'h00);
		for (int c = 0; c < 5; c++)
		begin
			smf_core_i.wr({3'h0, c[2:0], 2'h1});
			cyc(2);
			chk(trip, c[2:0]);
			chk(cv, lv[c]);
		end
		// short analog glitch: live status drops, flag must stay clear
		ana = 1'b0;
		cyc(50);
		rchk(8'hDF, 8'h91);
		cyc(40);
		chk(flag, 1'b0);
		chk(irq, 1'b0);
		ana = 1'b1;
		cyc(300);
		chk(flag, 1'b0);
		// sustained analog low
		ana = 1'b0;
		wait_flag(1'b1, 220);
		cyc(2);
		chk(irq, 1'b1);
		rchk(8'hDF, 8'hB3);
		smf_core_i.ien(1'b0);
		cyc(2);
		chk(irq, 1'b0);
		// recovery, a filtered drop in mid-settle, then a full settle
		ana = 1'b1;
		cyc(300);
		chk(flag, 1'b1);
		ana = 1'b0;
		cyc(250);
		ana = 1'b1;
		cyc(590);
		chk(flag, 1'b1);
		wait_flag(1'b0, 30);
		// digital low, software clear refused while low
		dig = 1'b0;
		wait_flag(1'b1, 220);
		rchk(8'hDF, 8'hB1);
		smf_core_i.wr(8'h11);
		cyc(2);
		chk(flag, 1'b1);
		dig = 1'b1;
		wait_flag(1'b0, 700);
		// software set, software clear, software set timed out
		smf_core_i.wr(8'h31);
		cyc(2);
		chk(flag, 1'b1);
		smf_core_i.wr(8'h11);
		cyc(2);
		chk(flag, 1'b0);
		smf_core_i.wr(8'h31);
		cyc(2);
		wait_flag(1'b0, 450);
		// monitor disabled: comparators ignored, no interrupt
		smf_core_i.ien(1'b1);
		smf_core_i.wr(8'h10);
		dig = 1'b0;
		cyc(300);
		chk(flag, 1'b0);
		chk(irq, 1'b0);
		print_verdict;
	end
endmodule
